/* verilog/irpe_pkg.sv */
// Shared constants for the infrared pulse encoder/decoder
`default_nettype none

package irpe_pkg;

  // APB address width and register indices; byte address is four times the index
  localparam int unsigned ADDR_W       = 12;
  localparam int unsigned DATA_W       = 32;
  localparam logic [11:0] CTRL_INDEX   = 12'h0BF;
  localparam logic [11:0] STAT_INDEX   = 12'h0C0;
  localparam logic [11:0] CTRL_ADDR    = 12'(CTRL_INDEX << 2);
  localparam logic [11:0] STAT_ADDR    = 12'(STAT_INDEX << 2);

  // endec_control layout
  localparam int unsigned CTRL_W       = 8;
  localparam logic [7:0]  CTRL_RESET   = 8'h00;
  localparam logic [7:0]  CTRL_MASK    = 8'h07;
  localparam int unsigned CTRL_EN_BIT   = 0;
  localparam int unsigned CTRL_RXEN_BIT = 1;
  localparam int unsigned CTRL_LOOP_BIT = 2;

  // endec_status layout (read only)
  localparam int unsigned STAT_TX_ACTIVE_BIT = 0;
  localparam int unsigned STAT_RX_ACTIVE_BIT = 1;
  localparam int unsigned STAT_FIFO_BIT      = 2;
  localparam int unsigned STAT_RXD_BIT       = 3;
  localparam int unsigned STAT_PIN_BIT       = 4;

  // Symbol timing in baud clocks
  localparam int unsigned BIT_TICKS        = 16;
  localparam int unsigned PULSE_START      = 7;
  localparam int unsigned PULSE_LEN        = 3;
  localparam int unsigned PULSE_TAIL       = 6;
  localparam int unsigned PHASE_W          = 4;
  localparam logic [3:0]  PHASE_FIRST      = 4'h0;
  localparam logic [3:0]  PHASE_LAST       = 4'(BIT_TICKS - 1);
  localparam logic [3:0]  PULSE_FIRST      = 4'(PULSE_START);
  localparam logic [3:0]  PULSE_LAST       = 4'(BIT_TICKS - PULSE_TAIL - 1);
  localparam logic [3:0]  PHASE_ONE        = 4'h1;

  // Buffering and activity timeout
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned IDLE_CELLS = 12;
  localparam int unsigned IDLE_W     = 4;

endpackage

`default_nettype wire

/* verilog/irpe_sync2.sv */
// Two flip-flop synchroniser for pin inputs
`default_nettype none

module irpe_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic [WIDTH-1:0] rst_val,
  input  wire logic [WIDTH-1:0] d,
  output var  logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta_reg;

  // Synchronous reset: loading a port value here is legal
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      meta_reg <= rst_val;
      q        <= rst_val;
    end
    else
    begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

`default_nettype wire

/* verilog/irpe_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
`default_nettype none

module irpe_fifo #(
  parameter int unsigned WIDTH = 1,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             clk,
  input  wire logic             srst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output var  logic             in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output var  logic             out_valid,
  input  wire logic             out_ready,
  output var  logic [WIDTH-1:0] out_data
);

  localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr_reg;
  logic [PTR_W-1:0] rd_ptr_reg;
  logic [CNT_W-1:0] count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != CNT_W'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data  = mem[rd_ptr_reg];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_data;
  end

  always_ff @(posedge clk)
  begin
    if (srst || flush)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == PTR_W'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end

endmodule

`default_nettype wire

/* verilog/irpe_top.sv */
// Infrared pulse encoder/decoder between the UART and an infrared transceiver
//
// Overview of operation
// - When enabled, encode UART transmit bits to pulses and decode pulses back.
// - Half-duplex on transmit only: no transmit starts while a receive is active (loopback off); receive is never blocked by transmit.
// - Bit timing comes from the UART baud clock, 9600 to 115.2 Kbps.
// - Each bit spans sixteen baud clocks; a one keeps the output low.
// - A zero is seven clocks low, three high, six low.
// - Decoder acts only with receive decoding enabled; otherwise input ignored.
// - Input high for a full sixteen-clock cell decodes as a one.
// - Seven high, three low, six high decodes as a zero.
// - First decoded bit may jitter; later bits are exactly sixteen clocks.
// - Internal loopback inverts the pulse output and feeds the receive path.
// - Control resets to zero; unused bits ignore writes and read zero.
// - Control bit 0 enable, bit 1 receive enable, bit 2 loopback.
`default_nettype none

module irpe_top
  import irpe_pkg::*;
#(
  parameter int unsigned IDLE_LIMIT = irpe_pkg::IDLE_CELLS,
  parameter int unsigned BUF_DEPTH  = irpe_pkg::FIFO_DEPTH
) (
  input  wire logic                        CLK_SYS,
  input  wire logic                        SRST,
  input  wire logic                        PSEL,
  input  wire logic                        PENABLE,
  input  wire logic                        PWRITE,
  input  wire logic [irpe_pkg::ADDR_W-1:0] PADDR,
  input  wire logic [irpe_pkg::DATA_W-1:0] PWDATA,
  output var  logic [irpe_pkg::DATA_W-1:0] PRDATA,
  output var  logic                        PREADY,
  output var  logic                        PSLVERR,
  input  wire logic                        BAUD_TICK,
  input  wire logic                        UART_TXD,
  output var  logic                        UART_RXD,
  output var  logic                        IR_PULSE_OUT,
  input  wire logic                        IR_PULSE_IN
);

  import irpe_pkg::*;

  // Control register and decoded fields
  logic [CTRL_W-1:0]  endec_control_reg;
  logic               endec_enable;
  logic               rx_decode_enable;
  logic               loopback_enable;

  // APB slave state
  logic               apb_access;
  logic               apb_done;
  logic               addr_ctrl;
  logic               addr_stat;
  logic [DATA_W-1:0]  rdata_next;

  // Encoder state
  logic               tx_active_reg;
  logic [PHASE_W-1:0] tx_phase_reg;
  logic               tx_bit_reg;
  logic [IDLE_W-1:0]  tx_ones_reg;
  logic               tx_start;

  // Decoder state
  logic               ir_pin_sync;
  logic               rx_src;
  logic               rx_src_prev_reg;
  logic               rx_active_reg;
  logic [PHASE_W-1:0] rx_phase_reg;
  logic               rx_zero_reg;
  logic [IDLE_W-1:0]  rx_ones_reg;
  logic               rx_run;
  logic               rx_stall;
  logic               rx_cell_end;
  logic               cell_bit;

  // Pending decoded bit waiting for buffer space
  logic               pend_valid_reg;
  logic               pend_bit_reg;

  // Buffer and UART-side replay stage
  logic               fifo_in_ready;
  logic               fifo_out_valid;
  logic               fifo_out_ready;
  logic               fifo_out_data;
  logic               out_busy_reg;
  logic [PHASE_W-1:0] out_phase_reg;
  logic               out_bit_reg;
  logic               out_last;

  assign endec_enable     = endec_control_reg[CTRL_EN_BIT];
  assign rx_decode_enable = endec_control_reg[CTRL_RXEN_BIT];
  assign loopback_enable  = endec_control_reg[CTRL_LOOP_BIT];

  // ---------------------------------------------------------------- APB slave
  assign apb_access = PSEL & PENABLE;
  assign apb_done   = apb_access & PREADY;
  assign addr_ctrl  = (PADDR == CTRL_ADDR);
  assign addr_stat  = (PADDR == STAT_ADDR);

  always_comb
  begin
    rdata_next = '0;
    if (addr_ctrl)
      rdata_next[CTRL_W-1:0] = endec_control_reg & CTRL_MASK;
    else if (addr_stat)
    begin
      rdata_next[STAT_TX_ACTIVE_BIT] = tx_active_reg;
      rdata_next[STAT_RX_ACTIVE_BIT] = rx_active_reg;
      rdata_next[STAT_FIFO_BIT]      = fifo_out_valid;
      rdata_next[STAT_RXD_BIT]       = UART_RXD;
      rdata_next[STAT_PIN_BIT]       = ir_pin_sync;
    end
  end

  // One wait state: answer is registered so every bus output comes from a flop
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
    begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end
    else if (apb_access && !PREADY)
    begin
      PREADY  <= 1'b1;
      PRDATA  <= PWRITE ? '0 : rdata_next;
      PSLVERR <= ~(addr_ctrl | addr_stat) | (PWRITE & addr_stat);
    end
    else
    begin
      PREADY  <= 1'b0;
      PRDATA  <= '0;
      PSLVERR <= 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      endec_control_reg <= CTRL_RESET;
    else if (apb_done && PWRITE && addr_ctrl)
      endec_control_reg <= PWDATA[CTRL_W-1:0] & CTRL_MASK;
  end

  // ---------------------------------------------------------------- Encoder
  // A start bit opens a run of cells; the UART shifts on the same baud tick,
  // so sampling its data one tick into each cell avoids racing its update.
  assign tx_start = BAUD_TICK & endec_enable & ~tx_active_reg & ~UART_TXD
                    & ~(rx_active_reg & ~loopback_enable);

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || !endec_enable)
    begin
      tx_active_reg <= 1'b0;
      tx_phase_reg  <= PHASE_FIRST;
      tx_bit_reg    <= 1'b1;
      tx_ones_reg   <= '0;
    end
    else if (tx_start)
    begin
      tx_active_reg <= 1'b1;
      tx_phase_reg  <= PHASE_FIRST;
      tx_bit_reg    <= 1'b0;
      tx_ones_reg   <= '0;
    end
    else if (BAUD_TICK && tx_active_reg)
    begin
      tx_phase_reg <= (tx_phase_reg == PHASE_LAST) ? PHASE_FIRST : tx_phase_reg + PHASE_ONE;
      if (tx_phase_reg == PHASE_FIRST)
        tx_bit_reg <= UART_TXD;
      if (tx_phase_reg == PHASE_LAST)
      begin
        if (!tx_bit_reg)
          tx_ones_reg <= '0;
        else if (tx_ones_reg == IDLE_W'(IDLE_LIMIT - 1))
          tx_active_reg <= 1'b0;
        else
          tx_ones_reg <= tx_ones_reg + 1'b1;
      end
    end
  end

  // Zero cells pulse high during ticks 7..9; ones and idle stay low
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      IR_PULSE_OUT <= 1'b0;
    else
      IR_PULSE_OUT <= endec_enable & tx_active_reg & ~tx_bit_reg
                      & (tx_phase_reg >= PULSE_FIRST) & (tx_phase_reg <= PULSE_LAST);
  end

  // ---------------------------------------------------------------- Decoder
  irpe_sync2 #(
    .WIDTH (1)
  ) u_pin_sync (
    .clk     (CLK_SYS),
    .srst    (SRST),
    .rst_val (1'b1),
    .d       (IR_PULSE_IN),
    .q       (ir_pin_sync)
  );

  // Loopback uses the inverted output so idle low becomes idle high
  assign rx_src = loopback_enable ? ~IR_PULSE_OUT : ir_pin_sync;

  assign rx_run      = endec_enable & rx_decode_enable;
  assign rx_stall    = pend_valid_reg & ~fifo_in_ready;
  assign rx_cell_end = BAUD_TICK & rx_active_reg & ~rx_stall & (rx_phase_reg == PHASE_LAST);
  assign cell_bit    = ~(rx_zero_reg | ~rx_src);

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || !rx_run)
      rx_src_prev_reg <= 1'b1;
    else if (BAUD_TICK)
      rx_src_prev_reg <= rx_src;
  end

  // The first falling edge fixes the cell phase at tick 7; sampling only on
  // baud ticks is why the first decoded bit can be off by up to one tick.
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || !rx_run)
    begin
      rx_active_reg <= 1'b0;
      rx_phase_reg  <= PHASE_FIRST;
      rx_zero_reg   <= 1'b0;
      rx_ones_reg   <= '0;
    end
    else if (BAUD_TICK && !rx_active_reg)
    begin
      if (rx_src_prev_reg && !rx_src)
      begin
        rx_active_reg <= 1'b1;
        rx_phase_reg  <= PULSE_FIRST + PHASE_ONE;
        rx_zero_reg   <= 1'b1;
        rx_ones_reg   <= '0;
      end
    end
    else if (BAUD_TICK && !rx_stall)
    begin
      if (rx_phase_reg == PHASE_LAST)
      begin
        rx_phase_reg <= PHASE_FIRST;
        rx_zero_reg  <= 1'b0;
        if (!cell_bit)
          rx_ones_reg <= '0;
        else if (rx_ones_reg == IDLE_W'(IDLE_LIMIT - 1))
          rx_active_reg <= 1'b0;
        else
          rx_ones_reg <= rx_ones_reg + 1'b1;
      end
      else
      begin
        rx_phase_reg <= rx_phase_reg + PHASE_ONE;
        if (!rx_src)
          rx_zero_reg <= 1'b1;
      end
    end
  end

  // Decoded bit waits here until the buffer takes it; a full buffer freezes the decoder
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || !rx_run)
    begin
      pend_valid_reg <= 1'b0;
      pend_bit_reg   <= 1'b1;
    end
    else if (rx_cell_end)
    begin
      pend_valid_reg <= 1'b1;
      pend_bit_reg   <= cell_bit;
    end
    else if (fifo_in_ready)
      pend_valid_reg <= 1'b0;
  end

  // ---------------------------------------------------------------- Buffer
  irpe_fifo #(
    .WIDTH (1),
    .DEPTH (BUF_DEPTH)
  ) u_bit_fifo (
    .clk       (CLK_SYS),
    .srst      (SRST),
    .flush     (~rx_run),
    .in_valid  (pend_valid_reg),
    .in_ready  (fifo_in_ready),
    .in_data   (pend_bit_reg),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_out_ready),
    .out_data  (fifo_out_data)
  );

  // ---------------------------------------------------------------- UART side
  // Bits start only on a baud tick, so the next decoded bit is already buffered
  // when the current one ends and the UART line never blips high between bits.
  assign out_last       = BAUD_TICK & (out_phase_reg == PHASE_LAST);
  assign fifo_out_ready = rx_run & ((~out_busy_reg & BAUD_TICK) | out_last);

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || !rx_run)
    begin
      out_busy_reg  <= 1'b0;
      out_phase_reg <= PHASE_FIRST;
      out_bit_reg   <= 1'b1;
    end
    else if (fifo_out_ready && fifo_out_valid)
    begin
      out_busy_reg  <= 1'b1;
      out_phase_reg <= PHASE_FIRST;
      out_bit_reg   <= fifo_out_data;
    end
    else if (out_last)
    begin
      out_busy_reg <= 1'b0;
      out_bit_reg  <= 1'b1;
    end
    else if (BAUD_TICK && out_busy_reg)
      out_phase_reg <= out_phase_reg + PHASE_ONE;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST)
      UART_RXD <= 1'b1;
    else
      UART_RXD <= ~rx_run | ~out_busy_reg | out_bit_reg;
  end

endmodule

`default_nettype wire

/* sim/irpe_chk.sv */
// Port checker for the infrared pulse encoder/decoder
`default_nettype none

module irpe_chk
  import irpe_pkg::*;
(
  input wire logic        CLK_SYS,
  input wire logic        SRST,
  input wire logic        PSEL,
  input wire logic        PENABLE,
  input wire logic        PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic        PREADY,
  input wire logic        PSLVERR,
  input wire logic        BAUD_TICK,
  input wire logic        UART_RXD,
  input wire logic        IR_PULSE_OUT
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] hi_reg;
  logic [3:0] lo_reg;
  logic [7:0] rxlo_reg;

  default clocking @(posedge CLK_SYS);
  endclocking
  default disable iff (SRST);

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || !IR_PULSE_OUT) hi_reg <= 4'h0;
    else if (BAUD_TICK) hi_reg <= hi_reg + 4'h1;
  end

  // Starts saturated so the first pulse after reset has no gap to judge
  always_ff @(posedge CLK_SYS)
  begin
    if (SRST) lo_reg <= 4'hF;
    else if (IR_PULSE_OUT) lo_reg <= 4'h0;
    else if (BAUD_TICK && lo_reg != 4'hF) lo_reg <= lo_reg + 4'h1;
  end

  always_ff @(posedge CLK_SYS)
  begin
    if (SRST || UART_RXD) rxlo_reg <= 8'h00;
    else if (BAUD_TICK) rxlo_reg <= rxlo_reg + 8'h01;
  end

  AST_TX_PULSE_WIDTH: assert property ($fell(IR_PULSE_OUT) |-> hi_reg == 4'h3)
    else $error("pulse width wrong");
  AST_TX_PULSE_GAP: assert property ($rose(IR_PULSE_OUT) |-> lo_reg >= 4'hD)
    else $error("pulse gap too short");
  AST_RX_BIT_WIDTH: assert property ($rose(UART_RXD) |-> rxlo_reg[3:0] == 4'h0 && rxlo_reg != 8'h00)
    else $error("decoded low run not whole bits");
  AST_APB_READY_TIME: assert property ($rose(PSEL && PENABLE) |=> PREADY)
    else $error("ready late");
  AST_APB_READY_PULSE: assert property (PREADY |=> !PREADY)
    else $error("ready held");
  AST_APB_RDATA_QUIET: assert property (!PREADY |-> PRDATA == 32'h0)
    else $error("read data outside answer");
  AST_APB_ERR_QUAL: assert property (PSLVERR |-> PREADY && PSEL && PENABLE)
    else $error("error without answer");
  AST_CTRL_UNUSED_ZERO: assert property (PREADY && !PWRITE && PADDR == CTRL_ADDR |-> PRDATA[31:3] == '0)
    else $error("control unused bits set");
  AST_RESET_OUTPUTS: assert property ($fell(SRST) |-> UART_RXD && !IR_PULSE_OUT && !PREADY)
    else $error("outputs not idle after reset");
  AST_RX_TICK_ALIGNED: assert property ($changed(UART_RXD) |-> $past(BAUD_TICK, 2))
    else $error("decoded bit edge off the baud grid");

  cover property ($rose(IR_PULSE_OUT));
  cover property ($fell(UART_RXD));
  cover property (PREADY && PSLVERR);
endmodule

`default_nettype wire

/* sim/irpe_xcvr.sv */
// Transceiver model: plays frames as receive pulses
`default_nettype none

module irpe_xcvr
(
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       tick,
  input  wire logic       go,
  input  wire logic [9:0] frame,
  input  wire logic       echo,
  input  wire logic       txp,
  output var  logic       pin,
  output var  logic       busy
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [9:0] sh_reg;
  logic [3:0] ph_reg;
  logic [3:0] n_reg;

  always_ff @(posedge clk)
  begin
    if (srst)
      busy <= 1'b0;
    else if (go && !busy)
    begin
      busy   <= 1'b1;
      sh_reg <= frame;
      ph_reg <= 4'h0;
      n_reg  <= 4'h0;
    end
    else if (busy && tick)
    begin
      ph_reg <= ph_reg + 4'h1;
      if (ph_reg == 4'hF)
      begin
        sh_reg <= sh_reg >> 1;
        n_reg  <= n_reg + 4'h1;
        busy   <= n_reg != 4'h9;
      end
    end
  end

  // Line idles high; low in phases 7..9 of a zero cell, or while an echoed pulse returns
  assign pin = !(busy && !sh_reg[0] && ph_reg >= 4'h7 && ph_reg <= 4'h9) && !(echo && txp);
endmodule

`default_nettype wire

/* sim/irpe_tb.sv */
// Self-checking bench for the infrared pulse encoder/decoder
`default_nettype none
`define CHK(nm, ex, gt) begin checks++; if ((gt) !== (ex)) begin error_cnt++; $display("mismatch %s exp %0h got %0h", nm, ex, gt); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import irpe_pkg::*;
  logic        clk       = 1'b0;
  logic        srst      = 1'b1;
  logic        psel      = 1'b0;
  logic        penable   = 1'b0;
  logic        pwrite    = 1'b0;
  logic [11:0] paddr     = 12'h000;
  logic [31:0] pwdata    = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        baud_tick = 1'b0;
  logic [1:0]  tick_cnt  = 2'h0;
  logic        uart_txd  = 1'b1;
  logic        uart_rxd;
  logic        ir_out;
  logic        ir_in;
  logic        xgo       = 1'b0;
  logic [9:0]  xframe    = 10'h3FF;
  logic        xecho     = 1'b0;
  logic        ir_prev   = 1'b0;
  logic        rxd_low   = 1'b0;
  logic [31:0] seed      = 32'h0000002A;
  int          pulses    = 0;
  int          error_cnt = 0;
  int          checks    = 0;

  irpe_top #(.IDLE_LIMIT(4), .BUF_DEPTH(4)) u_dut (
    .CLK_SYS(clk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .BAUD_TICK(baud_tick), .UART_TXD(uart_txd), .UART_RXD(uart_rxd),
    .IR_PULSE_OUT(ir_out), .IR_PULSE_IN(ir_in));
  irpe_xcvr u_xcvr (.clk(clk), .srst(srst), .tick(baud_tick), .go(xgo), .frame(xframe),
    .echo(xecho), .txp(ir_out), .pin(ir_in), .busy());

  always #5 clk = ~clk;

  // One baud tick every four system clocks
  always @(posedge clk)
  begin
    tick_cnt  <= tick_cnt + 2'h1;
    baud_tick <= tick_cnt == 2'h3;
    ir_prev   <= ir_out;
    if (ir_out && !ir_prev) pulses <= pulses + 1;
    if (uart_rxd !== 1'b1) rxd_low <= 1'b1;
  end

  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // Frame of start, byte, stop; first two bytes are the all-zero and all-one corners
  function logic [9:0] pick(input int k);
    logic [7:0] b;
    b = (k == 0) ? 8'h00 : (k == 1) ? 8'hFF : 8'(rnd());
    return {1'b1, b, 1'b0};
  endfunction

  function automatic int zeros(input logic [9:0] f);
    int z;
    z = 0;
    for (int i = 0; i < 10; i++) z += (f[i] == 1'b0);
    return z;
  endfunction

  task automatic stop_test();
    $display("checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic ticks(input int n);
    int k;
    repeat (n)
    begin
      @(posedge clk);
      k = 0;
      while (baud_tick !== 1'b1 && k < 8)
      begin
        @(posedge clk);
        k++;
      end
      if (k == 8) error_cnt++;
      if (k == 8) stop_test();
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n == 20) error_cnt++;
    if (n == 20) stop_test();
    @(posedge clk);
  endtask

  task automatic setc(input logic [7:0] v);
    logic [31:0] q;
    logic        e;
    apb(1'b1, CTRL_ADDR, {24'h0, v}, q, e);
  endtask

  task automatic xsend(input logic [9:0] f);
    xframe <= f;
    xgo    <= 1'b1;
    ticks(1);
    xgo    <= 1'b0;
  endtask

  task automatic send_txd(input logic [9:0] f);
    for (int i = 0; i < 10; i++)
    begin
      uart_txd <= f[i];
      ticks(16);
    end
  endtask

  // Finds the start bit, then samples each decoded bit near its middle
  task automatic get_rx(output logic [9:0] g);
    int n;
    n = 0;
    g = 10'h0;
    while (uart_rxd !== 1'b0 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) error_cnt++;
    if (n == 3000) stop_test();
    ticks(8);
    g[0] = uart_rxd;
    for (int i = 1; i < 10; i++)
    begin
      ticks(16);
      g[i] = uart_rxd;
    end
  endtask

  initial
  begin
    logic [31:0] q;
    logic        e;
    logic [31:0] w;
    logic [9:0]  f;
    logic [9:0]  g;
    repeat (4) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    apb(1'b0, CTRL_ADDR, 32'h0, q, e);
    `CHK("ctrl reset", 32'h0, q);
    apb(1'b0, STAT_ADDR, 32'h0, q, e);
    `CHK("status idle", 32'h00000018, q);
    w = rnd();
    apb(1'b1, CTRL_ADDR, w, q, e);
    apb(1'b0, CTRL_ADDR, 32'h0, q, e);
    `CHK("ctrl mask", w & 32'h00000007, q);
    apb(1'b0, 12'h004, 32'h0, q, e);
    `CHK("unmapped err", 1'b1, e);
    `CHK("unmapped data", 32'h0, q);
    apb(1'b1, STAT_ADDR, 32'hFFFFFFFF, q, e);
    `CHK("status write err", 1'b1, e);
    $display("test registers done");
    setc(8'h01);
    rxd_low = 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      f = pick(k);
      pulses = 0;
      xsend(f);
      send_txd(f);
      ticks(96);
      `CHK("tx pulses", zeros(f), pulses);
    end
    `CHK("rx ignored", 1'b0, rxd_low);
    $display("test transmit done");
    setc(8'h03);
    for (int k = 0; k < 4; k++)
    begin
      f = pick(k);
      xsend(f);
      get_rx(g);
      `CHK("rx frame", f, g);
      ticks(96);
    end
    $display("test receive done");
    setc(8'h07);
    for (int k = 0; k < 2; k++)
    begin
      f = pick(2);
      fork
        send_txd(f);
        get_rx(g);
      join
      `CHK("loop frame", f, g);
      ticks(96);
    end
    $display("test loopback done");
    setc(8'h03);
    xecho <= 1'b1;
    f = pick(2);
    fork
      send_txd(f);
      get_rx(g);
    join
    `CHK("echo frame", f, g);
    ticks(96);
    xecho <= 1'b0;
    $display("test external loopback done");
    setc(8'h00);
    pulses = 0;
    rxd_low = 1'b0;
    f = pick(2);
    xsend(f);
    send_txd(f);
    ticks(96);
    `CHK("off pulses", 0, pulses);
    `CHK("off rx", 1'b0, rxd_low);
    $display("test disabled done");
    stop_test();
  end
endmodule

bind irpe_top irpe_chk u_chk (
  .CLK_SYS(CLK_SYS), .SRST(SRST), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
  .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
  .BAUD_TICK(BAUD_TICK), .UART_RXD(UART_RXD), .IR_PULSE_OUT(IR_PULSE_OUT));

`undef CHK
`default_nettype wire
